/* File: shr_consts.vh */
// Constants for the sample capture and histogram memory unit
`ifndef SHR_CONSTS_VH
`define SHR_CONSTS_VH

// Register indices; byte address is four times the index
`define SHR_IDX_LOWER       8'h64
`define SHR_IDX_UPPER       8'h65
`define SHR_IDX_SCALE       8'h66
`define SHR_IDX_GROUPS      8'h67
`define SHR_IDX_COMMAND     8'h70
`define SHR_IDX_STATE       8'h71
`define SHR_IDX_POINTER     8'h72
`define SHR_IDX_WORD        8'h73
`define SHR_IDX_B_LOWER     8'h74
`define SHR_IDX_FLAGS       8'h78
`define SHR_IDX_MASK        8'h79
`define SHR_IDX_GROUP_SIZE  8'h7F

// Reset values
`define SHR_RST_ZERO        16'h0000
`define SHR_RST_GROUP_SIZE  16'hFFFF

// Command register fields
`define SHR_CMD_OP_HI       1
`define SHR_CMD_OP_LO       0
`define SHR_CMD_CLEAR_BIT   1
`define SHR_CMD_CHAN_BIT    2
`define SHR_CMD_SRC_HI      5
`define SHR_CMD_SRC_LO      3
`define SHR_CMD_MODE_HI     7
`define SHR_CMD_MODE_LO     6
`define SHR_OP_DISABLE      2'h0
`define SHR_OP_ENABLE       2'h1

// Sources and modes
`define SHR_SRC_FIRST       3'h1
`define SHR_SRC_LAST        3'h5
`define SHR_MODE_CAPTURE    2'h0
`define SHR_MODE_HIST_I     2'h1
`define SHR_MODE_HIST_Q     2'h2
`define SHR_MODE_HIST_MAG   2'h3

// Unit states as reported in the state register
`define SHR_ST_OFF          3'h0
`define SHR_ST_WAIT         3'h1
`define SHR_ST_ACTIVE       3'h2
`define SHR_ST_DONE         3'h3
`define SHR_ST_CLEAR        3'h4

// Flag bits
`define SHR_FLAG_DONE       0
`define SHR_FLAG_OVF        2

// Sizes
`define SHR_SAMPLE_W        18
`define SHR_PTR_W           11
`define SHR_LAST_PAIR       10'h3FF
`define SHR_LAST_LOC        11'h7FF
`define SHR_LAST_BIN        10'h3FF
`define SHR_SCALE_W         14
`define SHR_TAP_BITS        180

`endif

/* File: shr_top.v */
// Sample capture and histogram memory unit with Avalon-MM register access
// Operation
// [R1] Values at or below lower bound go to bin 0
// [R2] Values at or above upper bound go to bin 1023
// [R3] Index is integer part of difference times 14-bit scale
// [R4] Software keeps bounds and scale within 1023 bins
// [R5] Histogram observes group count times group size samples
// [R6] Command 00 disables, 01 enables, 1x clears
// [R7] Software clears memory before a histogram run
// [R8] Command bit 2 picks channel 0 or 1
// [R9] Source field picks input or stage 1 to 4
// [R10] Mode field picks capture, I, Q or magnitude squared
// [R11] Enabled unit waits for its sync before starting
// [R12] Periodic timer sync never starts the unit
// [R13] State field reports off, wait, active, done, clear
// [R14] Software polls state until clearing has finished
// [R15] Completion raises flag, interrupts when mask bit 0 set
// [R16] Bin overflow sets flag bit 2, mask bit 2 interrupts
// [R17] Pointer is 11 bits, upper bits reserved
// [R18] Capture stores I MSBs even, Q MSBs odd
// [R19] Bin count high half even, low half odd
// [R20] Word access uses pointer then advances it
// [R21] Unit stops after 1024 pairs or last group
// [R22] Clear zeroes all 2048 locations then turns off
//
// The Avalon-MM slave port was decided locally.
`default_nettype none
`include "shr_consts.vh"

module shr_top (
  input  wire        core_clk,
  input  wire        reset,
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire [179:0] tap_i_bus,
  input  wire [179:0] tap_q_bus,
  input  wire        sample_valid,
  input  wire        sync_pulse,
  input  wire        sync_periodic,
  output reg         irq
);

  // Byte-lane merge for 16-bit registers
  function [15:0] merge16;
    input [15:0] old_val;
    input [31:0] wdata;
    input [3:0]  be;
    begin
      merge16 = old_val;
      if (be[0])
        merge16[7:0] = wdata[7:0];
      if (be[1])
        merge16[15:8] = wdata[15:8];
    end
  endfunction

  reg [15:0]             mem [0:2047];
  reg [15:0]             lower_bound;
  reg [15:0]             upper_bound;
  reg [15:0]             bin_scale;
  reg [15:0]             group_count;
  reg [15:0]             group_size;
  reg [15:0]             b_lower_bound;
  reg [7:0]              command;
  reg [`SHR_PTR_W-1:0]   pointer;
  reg [2:0]              flags;
  reg [2:0]              mask;
  reg [2:0]              state;
  reg [2:0]              phase;
  reg                    chan_sel;
  reg [2:0]              src_sel;
  reg [1:0]              mode_sel;
  reg [`SHR_PTR_W-1:0]   clear_cnt;
  reg [9:0]              pair_cnt;
  reg [15:0]             smp_cnt;
  reg [15:0]             grp_cnt;
  reg [9:0]              bin_idx;
  reg [15:0]             hold_q;
  reg [15:0]             cnt_hi;
  reg [15:0]             cnt_lo;
  reg                    done_ev;
  reg                    ovf_ev;

  // Bus request decode
  wire       req      = (avs_read | avs_write) & avs_waitrequest;
  wire [7:0] reg_idx  = avs_address[9:2];
  wire       word_acc = req & (reg_idx == `SHR_IDX_WORD);
  wire       cmd_wr   = req & avs_write & (reg_idx == `SHR_IDX_COMMAND) & avs_byteenable[0];
  wire [15:0] cmd_wd  = merge16({8'h00, command}, avs_writedata, avs_byteenable);
  wire       stall    = word_acc;

  // Tap and channel selection
  wire       src_ok = (src_sel >= `SHR_SRC_FIRST) && (src_sel <= `SHR_SRC_LAST); // [R9]
  wire [2:0] tap_no = src_sel - `SHR_SRC_FIRST;
  wire [3:0] sel    = {tap_no, chan_sel}; // [R8] [R9]
  wire [`SHR_SAMPLE_W-1:0] samp_i = tap_i_bus[sel*`SHR_SAMPLE_W +: `SHR_SAMPLE_W];
  wire [`SHR_SAMPLE_W-1:0] samp_q = tap_q_bus[sel*`SHR_SAMPLE_W +: `SHR_SAMPLE_W];
  wire [15:0] i16 = samp_i[17:2]; // [R18]
  wire [15:0] q16 = samp_q[17:2]; // [R18]
  wire        take = sample_valid & src_ok & ~stall & (phase == 3'h0);

  // Histogram value and bin index
  wire signed [31:0] i_sq = $signed(i16) * $signed(i16);
  wire signed [31:0] q_sq = $signed(q16) * $signed(q16);
  wire [32:0] mag_sum = {1'b0, i_sq} + {1'b0, q_sq}; // [R10]
  reg  [16:0] val17;
  reg  [16:0] lo17;
  reg  [16:0] hi17;
  always @*
  begin
    case (mode_sel)
      `SHR_MODE_HIST_I:
      begin
        val17 = {i16[15], i16};
        lo17  = {lower_bound[15], lower_bound};
        hi17  = {upper_bound[15], upper_bound};
      end
      `SHR_MODE_HIST_Q:
      begin
        val17 = {q16[15], q16};
        lo17  = {lower_bound[15], lower_bound};
        hi17  = {upper_bound[15], upper_bound};
      end
      default:
      begin
        val17 = {1'b0, mag_sum[31:16]};
        lo17  = {1'b0, lower_bound};
        hi17  = {1'b0, upper_bound};
      end
    endcase
  end
  wire [16:0] diff  = val17 - lo17;
  wire [30:0] prod  = diff * bin_scale[`SHR_SCALE_W-1:0]; // [R3]
  wire [9:0]  bin_n = ($signed(val17) <= $signed(lo17)) ? 10'h000 :      // [R1]
                      ($signed(val17) >= $signed(hi17)) ? `SHR_LAST_BIN : // [R2]
                      prod[23:14]; // [R3]
  wire [31:0] cnt_inc = {cnt_hi, cnt_lo} + 32'h0000_0001;

  // Memory write port: bus first, then engine
  reg                  mem_we;
  reg [`SHR_PTR_W-1:0] mem_wa;
  reg [15:0]           mem_wd;
  always @*
  begin
    mem_we = 1'b0;
    mem_wa = pointer;
    mem_wd = 16'h0000;
    if (word_acc & avs_write)
    begin
      mem_we = 1'b1; // [R20]
      mem_wd = merge16(mem[pointer], avs_writedata, avs_byteenable);
    end
    else if (!stall && !cmd_wr)
    begin
      case (state)
        `SHR_ST_CLEAR:
        begin
          mem_we = 1'b1; // [R22]
          mem_wa = clear_cnt;
        end
        `SHR_ST_ACTIVE:
        begin
          if (mode_sel == `SHR_MODE_CAPTURE)
          begin
            if (take)
            begin
              mem_we = 1'b1; // [R18]
              mem_wa = {pair_cnt, 1'b0};
              mem_wd = i16;
            end
            else if (phase == 3'h1)
            begin
              mem_we = 1'b1; // [R18]
              mem_wa = {pair_cnt, 1'b1};
              mem_wd = hold_q;
            end
          end
          else if (phase == 3'h3)
          begin
            mem_we = 1'b1; // [R19]
            mem_wa = {bin_idx, 1'b1};
            mem_wd = cnt_inc[15:0];
          end
          else if (phase == 3'h4)
          begin
            mem_we = 1'b1; // [R19]
            mem_wa = {bin_idx, 1'b0};
            mem_wd = cnt_hi;
          end
        end
        default:
        begin
          mem_we = 1'b0;
        end
      endcase
    end
  end

  // Memory array write
  always @(posedge core_clk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  // Capture and histogram engine
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      state     <= `SHR_ST_OFF;
      phase     <= 3'h0;
      chan_sel  <= 1'b0;
      src_sel   <= 3'h0;
      mode_sel  <= `SHR_MODE_CAPTURE;
      clear_cnt <= {`SHR_PTR_W{1'b0}};
      pair_cnt  <= 10'h000;
      smp_cnt   <= 16'h0000;
      grp_cnt   <= 16'h0000;
      bin_idx   <= 10'h000;
      hold_q    <= 16'h0000;
      cnt_hi    <= 16'h0000;
      cnt_lo    <= 16'h0000;
      done_ev   <= 1'b0;
      ovf_ev    <= 1'b0;
    end
    else
    begin
      done_ev <= 1'b0;
      ovf_ev  <= 1'b0;
      if (cmd_wr)
      begin
        phase     <= 3'h0;
        clear_cnt <= {`SHR_PTR_W{1'b0}};
        if (cmd_wd[`SHR_CMD_CLEAR_BIT])
          state <= `SHR_ST_CLEAR; // [R6] [R22]
        else if (cmd_wd[`SHR_CMD_OP_HI:`SHR_CMD_OP_LO] == `SHR_OP_ENABLE)
        begin
          state    <= `SHR_ST_WAIT; // [R6] [R11]
          chan_sel <= cmd_wd[`SHR_CMD_CHAN_BIT]; // [R8]
          src_sel  <= cmd_wd[`SHR_CMD_SRC_HI:`SHR_CMD_SRC_LO]; // [R9]
          mode_sel <= cmd_wd[`SHR_CMD_MODE_HI:`SHR_CMD_MODE_LO]; // [R10]
        end
        else
          state <= `SHR_ST_OFF; // [R6]
      end
      else if (!stall)
      begin
        case (state)
          `SHR_ST_CLEAR:
          begin
            clear_cnt <= clear_cnt + 1'b1;
            if (clear_cnt == `SHR_LAST_LOC)
              state <= `SHR_ST_OFF; // [R22]
          end
          `SHR_ST_WAIT:
          begin
            pair_cnt <= 10'h000;
            smp_cnt  <= 16'h0000;
            grp_cnt  <= 16'h0000;
            if (sync_pulse && !sync_periodic)
              state <= `SHR_ST_ACTIVE; // [R11] [R12]
          end
          `SHR_ST_ACTIVE:
          begin
            if (mode_sel == `SHR_MODE_CAPTURE)
            begin
              if (take)
              begin
                hold_q <= q16;
                phase  <= 3'h1;
              end
              else if (phase == 3'h1)
              begin
                phase    <= 3'h0;
                pair_cnt <= pair_cnt + 1'b1;
                if (pair_cnt == `SHR_LAST_PAIR)
                begin
                  state   <= `SHR_ST_DONE; // [R21]
                  done_ev <= 1'b1; // [R15]
                end
              end
            end
            else
            begin
              case (phase)
                3'h0:
                begin
                  if (grp_cnt >= group_count)
                  begin
                    state   <= `SHR_ST_DONE; // [R5] [R21]
                    done_ev <= 1'b1; // [R15]
                  end
                  else if (take)
                  begin
                    bin_idx <= bin_n;
                    phase   <= 3'h1;
                    if (smp_cnt + 16'h0001 >= group_size)
                    begin
                      smp_cnt <= 16'h0000;
                      grp_cnt <= grp_cnt + 16'h0001; // [R5]
                    end
                    else
                      smp_cnt <= smp_cnt + 16'h0001; // [R5]
                  end
                end
                3'h1:
                begin
                  cnt_hi <= mem[{bin_idx, 1'b0}]; // [R19]
                  phase  <= 3'h2;
                end
                3'h2:
                begin
                  cnt_lo <= mem[{bin_idx, 1'b1}]; // [R19]
                  phase  <= 3'h3;
                end
                3'h3:
                begin
                  cnt_hi <= cnt_inc[31:16];
                  if ({cnt_hi, cnt_lo} == 32'hFFFF_FFFF)
                    ovf_ev <= 1'b1; // [R16]
                  phase <= 3'h4;
                end
                default:
                  phase <= 3'h0;
              endcase
            end
          end
          default:
            phase <= 3'h0;
        endcase
      end
    end
  end

  // Register file, pointer, flags and bus answer
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      lower_bound     <= `SHR_RST_ZERO;
      upper_bound     <= `SHR_RST_ZERO;
      bin_scale       <= `SHR_RST_ZERO;
      group_count     <= `SHR_RST_ZERO;
      group_size      <= `SHR_RST_GROUP_SIZE;
      b_lower_bound   <= `SHR_RST_ZERO;
      command         <= 8'h00;
      pointer         <= {`SHR_PTR_W{1'b0}};
      flags           <= 3'h0;
      mask            <= 3'h0;
      irq             <= 1'b0;
    end
    else
    begin
      avs_waitrequest <= ~req;
      irq             <= |(flags & mask); // [R15] [R16]
      if (req & avs_write)
      begin
        case (reg_idx)
          `SHR_IDX_LOWER:      lower_bound   <= merge16(lower_bound, avs_writedata, avs_byteenable);
          `SHR_IDX_UPPER:      upper_bound   <= merge16(upper_bound, avs_writedata, avs_byteenable);
          `SHR_IDX_SCALE:      bin_scale     <= merge16(bin_scale, avs_writedata, avs_byteenable);
          `SHR_IDX_GROUPS:     group_count   <= merge16(group_count, avs_writedata, avs_byteenable);
          `SHR_IDX_GROUP_SIZE: group_size    <= merge16(group_size, avs_writedata, avs_byteenable);
          `SHR_IDX_B_LOWER:    b_lower_bound <= merge16(b_lower_bound, avs_writedata, avs_byteenable);
          `SHR_IDX_COMMAND:    command       <= cmd_wd[7:0];
          `SHR_IDX_MASK:       mask          <= avs_writedata[2:0] & 3'h5;
          default:             command       <= command;
        endcase
      end
      // Pointer: host load or advance after a word access
      if (word_acc)
        pointer <= pointer + 1'b1; // [R20]
      else if (req & avs_write & (reg_idx == `SHR_IDX_POINTER))
        pointer <= avs_writedata[`SHR_PTR_W-1:0]; // [R17]
      // Sticky flags, write one to clear, set wins
      flags <= (flags & ~((req & avs_write & (reg_idx == `SHR_IDX_FLAGS)) ?
                          avs_writedata[2:0] : 3'h0))
               | {ovf_ev, 1'b0, done_ev}; // [R15] [R16]
      if (req & avs_read)
      begin
        case (reg_idx)
          `SHR_IDX_LOWER:      avs_readdata <= {16'h0000, lower_bound};
          `SHR_IDX_UPPER:      avs_readdata <= {16'h0000, upper_bound};
          `SHR_IDX_SCALE:      avs_readdata <= {16'h0000, bin_scale};
          `SHR_IDX_GROUPS:     avs_readdata <= {16'h0000, group_count};
          `SHR_IDX_GROUP_SIZE: avs_readdata <= {16'h0000, group_size};
          `SHR_IDX_B_LOWER:    avs_readdata <= {16'h0000, b_lower_bound};
          `SHR_IDX_COMMAND:    avs_readdata <= {24'h000000, command};
          `SHR_IDX_STATE:      avs_readdata <= {29'h0, state}; // [R13]
          `SHR_IDX_POINTER:    avs_readdata <= {21'h0, pointer}; // [R17]
          `SHR_IDX_WORD:       avs_readdata <= {16'h0000, mem[pointer]}; // [R20]
          `SHR_IDX_FLAGS:      avs_readdata <= {29'h0, flags};
          `SHR_IDX_MASK:       avs_readdata <= {29'h0, mask};
          default:             avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // shr_top
`default_nettype wire

/* File: shr_top_chk.sv */
// Concurrent checks on the register bus ports of the capture unit
`default_nettype none
`include "shr_consts.vh"
module shr_top_chk (
  input wire logic         core_clk,
  input wire logic         reset,
  input wire logic [9:0]   avs_address,
  input wire logic         avs_read,
  input wire logic         avs_write,
  input wire logic [31:0]  avs_writedata,
  input wire logic [3:0]   avs_byteenable,
  input wire logic [31:0]  avs_readdata,
  input wire logic         avs_waitrequest,
  input wire logic [179:0] tap_i_bus,
  input wire logic [179:0] tap_q_bus,
  input wire logic         sample_valid,
  input wire logic         sync_pulse,
  input wire logic         sync_periodic,
  input wire logic         irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Handshake: one cycle to answer, one cycle of acknowledge
  a_ack_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge longer than one cycle");
  a_no_spurious: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge without a request");
  // Outputs quiet once reset is released
  a_reset_quiet: assert property ($fell(reset) |-> avs_waitrequest && !irq && avs_readdata == 32'h0)
    else $error("outputs not at reset values");
  // Read data shape and holding
  a_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_data_holds: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (avs_read && avs_waitrequest &&
    avs_address[9:2] < `SHR_IDX_LOWER |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_state_field: assert property (avs_read && avs_waitrequest &&
    avs_address[9:2] == `SHR_IDX_STATE |=> avs_readdata[15:3] == 13'h0 &&
    avs_readdata[2:0] <= `SHR_ST_CLEAR)
    else $error("state field out of range");
  a_ptr_field: assert property (avs_read && avs_waitrequest &&
    avs_address[9:2] == `SHR_IDX_POINTER |=> avs_readdata[15:11] == 5'h00)
    else $error("pointer reserved bits set");
endmodule // shr_top_chk
`default_nettype wire

/* File: shr_sample_src.sv */
// Model of the sample datapath feeding the capture unit
`default_nettype none
module shr_sample_src (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [15:0]  lvl_i,
  input  wire logic [15:0]  lvl_q,
  input  wire logic         slow,
  output var  logic [179:0] tap_i_bus,
  output var  logic [179:0] tap_q_bus,
  output var  logic         sample_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pace;
  // Pacing: every cycle, or one in three when slow
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      pace         <= 2'h0;
      sample_valid <= 1'h0;
    end
    else
    begin
      pace         <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
      sample_valid <= !slow || (pace == 2'h0);
    end
  end
  // Distinct value per slice, inverted while not valid
  always_comb
  begin
    for (int n = 0; n < 10; n++)
    begin
      tap_i_bus[n*18 +: 18] = {lvl_i + 16'(n), 2'h1} ^ {18{!sample_valid}};
      tap_q_bus[n*18 +: 18] = {lvl_q - 16'(n), 2'h2} ^ {18{!sample_valid}};
    end
  end
endmodule // shr_sample_src
`default_nettype wire

/* File: shr_top_tb_top.sv */
// Self-checking bench for the capture and histogram memory unit
`default_nettype none
`include "shr_consts.vh"
module shr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic         core_clk       = 1'h0;
  logic         reset          = 1'h1;
  logic [9:0]   avs_address    = 10'h000;
  logic         avs_read       = 1'h0;
  logic         avs_write      = 1'h0;
  logic [31:0]  avs_writedata  = 32'h0;
  logic [3:0]   avs_byteenable = 4'h3;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic [179:0] tap_i_bus;
  logic [179:0] tap_q_bus;
  logic         sample_valid;
  logic         sync_pulse     = 1'h0;
  logic         sync_periodic  = 1'h0;
  logic         irq;
  logic [15:0]  lvl_i          = 16'h4A50;
  logic [15:0]  lvl_q          = 16'h0B60;
  logic         slow           = 1'h0;
  int           n_errors       = 0;
  int           compares       = 0;
  localparam logic [7:0] RST_IDX [10] = '{8'h64, 8'h65, 8'h66, 8'h67, 8'h70,
                                          8'h71, 8'h72, 8'h74, 8'h10, 8'h7F};

  shr_top dut_u (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tap_i_bus(tap_i_bus), .tap_q_bus(tap_q_bus),
    .sample_valid(sample_valid), .sync_pulse(sync_pulse),
    .sync_periodic(sync_periodic), .irq(irq));
  shr_sample_src src_u (.core_clk(core_clk), .reset(reset), .lvl_i(lvl_i), .lvl_q(lvl_q),
    .slow(slow), .tap_i_bus(tap_i_bus), .tap_q_bus(tap_q_bus), .sample_valid(sample_valid));

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  task automatic complete_run;
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One bus transfer, held until waitrequest is sampled low
  task automatic bus_xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                          output logic [15:0] rd);
    int n;
    avs_address   <= {idx, 2'h0};
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_writedata <= {16'h0000, wd};
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    check("bus answer", 16'h0000, (n >= 50) ? 16'h0001 : 16'h0000);
    rd = avs_readdata[15:0];
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [15:0] dummy;
    bus_xfer(1'h1, idx, d, dummy);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp, input string nm);
    logic [15:0] d;
    bus_xfer(1'h0, idx, 16'h0000, d);
    check(nm, exp, d);
  endtask

  task automatic wait_state(input logic [2:0] st);
    int k;
    logic [15:0] d;
    k = 0;
    do
    begin
      bus_xfer(1'h0, `SHR_IDX_STATE, 16'h0000, d);
      k++;
    end while (d !== {13'h0, st} && k < 3000);
    check("state", {13'h0, st}, d);
  endtask

  task automatic pulse_sync(input logic periodic);
    sync_pulse    <= 1'h1;
    sync_periodic <= periodic;
    @(posedge core_clk);
    sync_pulse    <= 1'h0;
    sync_periodic <= 1'h0;
    @(posedge core_clk);
  endtask

  task automatic t_reset;
    foreach (RST_IDX[k])
      rd_chk(RST_IDX[k], (RST_IDX[k] == 8'h7F) ? 16'hFFFF : 16'h0000, "reset value");
  endtask

  task automatic t_clear;
    wr(`SHR_IDX_COMMAND, 16'h00C2);
    rd_chk(`SHR_IDX_STATE, 16'h0004, "state clearing");
    wait_state(`SHR_ST_OFF);
    wr(`SHR_IDX_POINTER, 16'h07FE);
    rd_chk(`SHR_IDX_WORD, 16'h0000, "cleared word");
    rd_chk(`SHR_IDX_WORD, 16'h0000, "cleared last word");
    rd_chk(`SHR_IDX_POINTER, 16'h0000, "pointer wrap");
  endtask

  // Capture from every tap, channel alternating, pacing varied
  task automatic t_capture;
    int n;
    wr(`SHR_IDX_MASK, 16'h0001);
    for (int s = 1; s <= 5; s++)
    begin
      n = (s - 1) * 2 + s % 2;
      slow <= s[1];
      wr(`SHR_IDX_COMMAND, 16'h00FC);
      rd_chk(`SHR_IDX_STATE, 16'h0000, "state off");
      wr(`SHR_IDX_COMMAND, {8'h00, 2'h0, s[2:0], s[0], 2'h1});
      pulse_sync(1'h1);
      rd_chk(`SHR_IDX_STATE, 16'h0001, "state waiting");
      pulse_sync(1'h0);
      wait_state(`SHR_ST_DONE);
      wr(`SHR_IDX_POINTER, 16'h0000);
      rd_chk(`SHR_IDX_WORD, lvl_i + n[15:0], "captured i");
      rd_chk(`SHR_IDX_WORD, lvl_q - n[15:0], "captured q");
      rd_chk(`SHR_IDX_FLAGS, 16'h0001, "done flag");
      check("irq", 16'h0001, {15'h0, irq});
      wr(`SHR_IDX_FLAGS, 16'h0001);
      check("irq cleared", 16'h0000, {15'h0, irq});
    end
  endtask

  // Histogram of six samples into one expected bin
  task automatic t_hist(input logic [1:0] mode, input logic [15:0] li, input logic [15:0] lq,
                        input logic [9:0] bin);
    wr(`SHR_IDX_COMMAND, 16'h0002);
    wait_state(`SHR_ST_OFF);
    lvl_i <= li;
    lvl_q <= lq;
    slow  <= mode[0];
    wr(`SHR_IDX_COMMAND, {8'h00, mode, 3'h1, 1'h0, 2'h1});
    pulse_sync(1'h0);
    wait_state(`SHR_ST_DONE);
    rd_chk(`SHR_IDX_FLAGS, 16'h0001, "hist done flag");
    check("irq masked", 16'h0000, {15'h0, irq});
    wr(`SHR_IDX_FLAGS, 16'h0001);
    wr(`SHR_IDX_POINTER, {5'h00, bin, 1'h0});
    rd_chk(`SHR_IDX_WORD, 16'h0000, "bin high");
    rd_chk(`SHR_IDX_WORD, 16'h0006, "bin low");
    rd_chk(`SHR_IDX_WORD, 16'h0000, "next bin");
  endtask

  // Preloaded full bin wraps and raises the overflow flag
  task automatic t_ovf;
    wr(`SHR_IDX_COMMAND, 16'h0002);
    wait_state(`SHR_ST_OFF);
    wr(`SHR_IDX_POINTER, 16'h07FE);
    wr(`SHR_IDX_WORD, 16'hFFFF);
    wr(`SHR_IDX_WORD, 16'hFFFF);
    lvl_i <= 16'h1388;
    wr(`SHR_IDX_COMMAND, 16'h0049);
    pulse_sync(1'h0);
    wait_state(`SHR_ST_DONE);
    rd_chk(`SHR_IDX_FLAGS, 16'h0005, "overflow flag");
    check("irq overflow", 16'h0001, {15'h0, irq});
    wr(`SHR_IDX_POINTER, 16'h07FE);
    rd_chk(`SHR_IDX_WORD, 16'h0000, "wrapped high");
    rd_chk(`SHR_IDX_WORD, 16'h0005, "wrapped low");
    wr(`SHR_IDX_FLAGS, 16'h0005);
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge core_clk);
    reset <= 1'h0;
    @(posedge core_clk);
    t_reset;
    t_clear;
    t_capture;
    wr(`SHR_IDX_MASK, 16'h0004);
    wr(`SHR_IDX_LOWER, 16'h0064);
    wr(`SHR_IDX_UPPER, 16'h0463);
    wr(`SHR_IDX_SCALE, 16'h3FFF);
    wr(`SHR_IDX_GROUPS, 16'h0002);
    wr(`SHR_IDX_GROUP_SIZE, 16'h0003);
    t_hist(`SHR_MODE_HIST_I, 16'h1388, 16'h0000, 10'h3FF);
    t_hist(`SHR_MODE_HIST_Q, 16'h0000, 16'hFF00, 10'h000);
    t_hist(`SHR_MODE_HIST_I, 16'h006E, 16'h0000, 10'h009);
    t_hist(`SHR_MODE_HIST_MAG, 16'h1000, 16'h1000, 10'h19B);
    t_ovf;
    complete_run;
  end

  // Watchdog against a hang
  initial
  begin
    #2000000;
    n_errors++;
    complete_run;
  end
endmodule // shr_top_tb_top

bind shr_top shr_top_chk chk_u (.core_clk(core_clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .tap_i_bus(tap_i_bus), .tap_q_bus(tap_q_bus), .sample_valid(sample_valid),
  .sync_pulse(sync_pulse), .sync_periodic(sync_periodic), .irq(irq));
`default_nettype wire
